// [sat_pkg.sv]
// Constants shared by the serial transmitter and its far-end receiver
package sat_pkg;
   localparam int SAT_DIV_W = 13;
   localparam int SAT_OVERSAMPLE = 16;
   localparam logic [12:0] SAT_DIV_RST = 13'h0004;
   localparam int SAT_FRAME_W = 11;
   localparam logic [3:0] SAT_FRAME_LEN_8 = 4'hA;
   localparam logic [3:0] SAT_FRAME_LEN_9 = 4'hB;
   localparam logic [3:0] SAT_RT_LAST = 4'hF;
   localparam logic [3:0] SAT_RT_MID = 4'h8;
   // Register byte offsets
   localparam logic [7:0] SAT_OFS_BAUD = 8'h00;
   localparam logic [7:0] SAT_OFS_CTRL1 = 8'h04;
   localparam logic [7:0] SAT_OFS_CTRL2 = 8'h08;
   localparam logic [7:0] SAT_OFS_STATUS1 = 8'h0C;
   localparam logic [7:0] SAT_OFS_DATA_HI = 8'h10;
   localparam logic [7:0] SAT_OFS_DATA_LO = 8'h14;
   localparam logic [7:0] SAT_OFS_PORT_OUT = 8'h18;
   localparam logic [7:0] SAT_OFS_PORT_DIR = 8'h1C;
   // Field positions
   localparam int SAT_C1_NINE = 0;
   localparam int SAT_C1_PAR_EN = 1;
   localparam int SAT_C1_PAR_ODD = 2;
   localparam int SAT_C2_TX_EN = 0;
   localparam int SAT_C2_TX_IRQ_EN = 1;
   localparam int SAT_S1_EMPTY = 0;
   localparam int SAT_S1_COMPLETE = 1;
   localparam int SAT_DH_NINTH = 0;
   localparam int SAT_PORT_TX_BIT = 1;
   // Reset values
   localparam logic [2:0] SAT_CTRL1_RST = 3'h0;
   localparam logic [1:0] SAT_CTRL2_RST = 2'h0;
   localparam logic [7:0] SAT_PORT_RST = 8'h00;
endpackage

// [sat_if.sv]
// Serial line between the transmitter end and the far-end receiver
`timescale 1ns/1ns
`default_nettype none
interface sat_if;
   logic txd_o;
   logic txd_oe;
   logic line;
   // Undriven line floats high through the pull-up
   assign line = txd_oe ? txd_o : 1'b1;
   modport dev (output txd_o, output txd_oe);
   modport far (input line);
endinterface
`default_nettype wire

// [sat_tx_dev.sv]
// Serial transmitter with baud generator and APB register file
//
// Contract
// - frame is start, 8/9 data, stop bit
// - ninth bit from data high, kept after sending
// - one 13-bit divisor counter sets bit timing
// - rx clock is clk/div, tx bit per 16
// - baud tick resynchronised before serial logic
// - shift register sends; data regs hold character
// - software enables, reads status, then writes data
// - enable rising loads all-ones preamble, 10/11 bits
// - after preamble load data with start, stop
// - odd/even parity replaces character MSB
// - holding empty set when character moves out
// - interrupt when empty flag and enable set
// - line idles high when nothing shifts
// - disable finishes frame, drops pending, releases pin
// - software waits empty flag before disabling
// - message gap: last byte, wait, toggle enable
// - released pin follows port S bit 1
// - tx and rx share baud tick independently
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module sat_tx_dev
   import sat_pkg::*;
#(
   parameter int DIV_W = SAT_DIV_W
) (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic IRQ,
   output logic BAUD_RT_TICK,
   sat_if.dev LINK
);
   typedef enum logic {SAT_TX_IDLE, SAT_TX_SHIFT} sat_tx_state_t;

   logic [DIV_W-1:0] baud_divisor_r, cnt_r;
   logic [2:0] ctrl1_r;
   logic [1:0] ctrl2_r;
   logic [7:0] hold_r, port_out_r, port_dir_r;
   logic [3:0] sub_r, bits_left_r, frame_len;
   logic tx_ninth_bit_r, empty_r, complete_r, armed_r, rt_raw_r, rt_sync_r;
   logic en_prev_r, preamble_due_r, txd_o_r, txd_oe_r;
   sat_tx_state_t state_r;
   logic [SAT_FRAME_W-1:0] shreg_r, frame;

   logic tx_enable, nine, access, wr_en, rd_en, mapped, bit_tick, slot, load_pre, load_data;
   logic [8:0] ch9;
   logic [31:0] rd_val;

   assign tx_enable = ctrl2_r[SAT_C2_TX_EN];
   assign nine = ctrl1_r[SAT_C1_NINE];
   assign access = PSEL && PENABLE;
   assign wr_en = access && PREADY && PWRITE;
   assign rd_en = access && PREADY && !PWRITE;
   assign frame_len = nine ? SAT_FRAME_LEN_9 : SAT_FRAME_LEN_8;
   assign bit_tick = rt_sync_r && (sub_r == SAT_RT_LAST);
   assign slot = bit_tick && (state_r == SAT_TX_IDLE || bits_left_r == 4'h1);
   assign load_pre = slot && tx_enable && preamble_due_r;
   assign load_data = slot && tx_enable && !preamble_due_r && !empty_r;

   always_comb begin
      ch9 = {tx_ninth_bit_r, hold_r};
      if (ctrl1_r[SAT_C1_PAR_EN]) begin
         if (nine) begin
            ch9[8] = ctrl1_r[SAT_C1_PAR_ODD] ? ~^hold_r : ^hold_r;
         end else begin
            ch9[7] = ctrl1_r[SAT_C1_PAR_ODD] ? ~^hold_r[6:0] : ^hold_r[6:0];
         end
      end
      // Unused top bit in 8-bit mode is a spare one; the bit count stops before it
      if (nine) begin
         frame = {1'b1, ch9, 1'b0};
      end else begin
         frame = {2'b11, ch9[7:0], 1'b0};
      end
   end

   always_comb begin
      mapped = 1'b1;
      rd_val = 32'h0000_0000;
      case (PADDR)
         SAT_OFS_BAUD: rd_val[DIV_W-1:0] = baud_divisor_r;
         SAT_OFS_CTRL1: rd_val[2:0] = ctrl1_r;
         SAT_OFS_CTRL2: rd_val[1:0] = ctrl2_r;
         SAT_OFS_STATUS1: begin
            rd_val[SAT_S1_EMPTY] = empty_r;
            rd_val[SAT_S1_COMPLETE] = complete_r;
         end
         SAT_OFS_DATA_HI: rd_val[SAT_DH_NINTH] = tx_ninth_bit_r;
         SAT_OFS_DATA_LO: rd_val = 32'h0000_0000;
         SAT_OFS_PORT_OUT: rd_val[7:0] = port_out_r;
         SAT_OFS_PORT_DIR: rd_val[7:0] = port_dir_r;
         default: mapped = 1'b0;
      endcase
   end

   // One wait state: ready and read data are both registered
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         PREADY <= 1'b0;
         PRDATA <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= access && !PREADY;
         if (access && !PREADY) begin
            PRDATA <= PWRITE ? 32'h0000_0000 : rd_val;
            PSLVERR <= !mapped;
         end else begin
            PSLVERR <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         baud_divisor_r <= DIV_W'(SAT_DIV_RST);
         ctrl1_r <= SAT_CTRL1_RST;
         ctrl2_r <= SAT_CTRL2_RST;
         port_out_r <= SAT_PORT_RST;
         port_dir_r <= SAT_PORT_RST;
         tx_ninth_bit_r <= 1'b0;
         hold_r <= 8'h00;
      end else if (wr_en) begin
         case (PADDR)
            SAT_OFS_BAUD: baud_divisor_r <= PWDATA[DIV_W-1:0];
            SAT_OFS_CTRL1: ctrl1_r <= PWDATA[2:0];
            SAT_OFS_CTRL2: ctrl2_r <= PWDATA[1:0];
            SAT_OFS_DATA_HI: tx_ninth_bit_r <= PWDATA[SAT_DH_NINTH];
            SAT_OFS_DATA_LO: hold_r <= PWDATA[7:0];
            SAT_OFS_PORT_OUT: port_out_r <= PWDATA[7:0];
            SAT_OFS_PORT_DIR: port_dir_r <= PWDATA[7:0];
            default: ;
         endcase
      end
   end

   // Status read arms the flag clear; the data write completes it
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         armed_r <= 1'b0;
      end else if (wr_en && PADDR == SAT_OFS_DATA_LO) begin
         armed_r <= 1'b0;
      end else if (rd_en && PADDR == SAT_OFS_STATUS1 && empty_r) begin
         armed_r <= 1'b1;
      end
   end

   // Hardware set wins over the software clear in the same cycle
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         empty_r <= 1'b1;
      end else if (load_data) begin
         empty_r <= 1'b1;
      end else if (!tx_enable && state_r == SAT_TX_IDLE) begin
         empty_r <= 1'b1;
      end else if (wr_en && PADDR == SAT_OFS_DATA_LO && armed_r) begin
         empty_r <= 1'b0;
      end
   end

   // Baud counter counts down and reloads; divisor zero holds it still
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         cnt_r <= '0;
         rt_raw_r <= 1'b0;
      end else if (baud_divisor_r == '0) begin
         cnt_r <= '0;
         rt_raw_r <= 1'b0;
      end else if (cnt_r <= DIV_W'(1)) begin
         cnt_r <= baud_divisor_r;
         rt_raw_r <= 1'b1;
      end else begin
         cnt_r <= cnt_r - DIV_W'(1);
         rt_raw_r <= 1'b0;
      end
   end

   // Extra stage costs a cycle of phase but decouples the counter path
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rt_sync_r <= 1'b0;
         BAUD_RT_TICK <= 1'b0;
         sub_r <= 4'h0;
      end else begin
         rt_sync_r <= rt_raw_r;
         BAUD_RT_TICK <= rt_raw_r;
         if (rt_sync_r) begin
            sub_r <= sub_r + 4'h1;
         end
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         en_prev_r <= 1'b0;
         preamble_due_r <= 1'b0;
      end else begin
         en_prev_r <= tx_enable;
         if (tx_enable && !en_prev_r) begin
            preamble_due_r <= 1'b1;
         end else if (load_pre) begin
            preamble_due_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         state_r <= SAT_TX_IDLE;
         shreg_r <= '1;
         bits_left_r <= 4'h0;
         complete_r <= 1'b1;
      end else if (bit_tick) begin
         case (state_r)
            SAT_TX_IDLE, SAT_TX_SHIFT: begin
               if (load_pre) begin
                  shreg_r <= '1;
                  bits_left_r <= frame_len;
                  state_r <= SAT_TX_SHIFT;
                  complete_r <= 1'b0;
               end else if (load_data) begin
                  shreg_r <= frame;
                  bits_left_r <= frame_len;
                  state_r <= SAT_TX_SHIFT;
                  complete_r <= 1'b0;
               end else if (slot) begin
                  state_r <= SAT_TX_IDLE;
                  bits_left_r <= 4'h0;
                  complete_r <= 1'b1;
               end else begin
                  shreg_r <= {1'b1, shreg_r[SAT_FRAME_W-1:1]};
                  bits_left_r <= bits_left_r - 4'h1;
               end
            end
            default: state_r <= SAT_TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         txd_o_r <= 1'b1;
         txd_oe_r <= 1'b0;
         IRQ <= 1'b0;
      end else begin
         IRQ <= empty_r && ctrl2_r[SAT_C2_TX_IRQ_EN];
         if (state_r == SAT_TX_SHIFT) begin
            txd_o_r <= shreg_r[0];
            txd_oe_r <= 1'b1;
         end else if (tx_enable) begin
            txd_o_r <= 1'b1;
            txd_oe_r <= 1'b1;
         end else begin
            txd_o_r <= port_out_r[SAT_PORT_TX_BIT];
            txd_oe_r <= port_dir_r[SAT_PORT_TX_BIT];
         end
      end
   end

   assign LINK.txd_o = txd_o_r;
   assign LINK.txd_oe = txd_oe_r;
endmodule // sat_tx_dev
`default_nettype wire

// [sat_rx_far.sv]
// Far-end serial receiver that recovers frames from the line
`timescale 1ns/1ns
`default_nettype none
module sat_rx_far
   import sat_pkg::*;
#(
   parameter int DIV_W = SAT_DIV_W
) (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic [DIV_W-1:0] DIVISOR,
   input wire logic NINE_BIT,
   output logic [8:0] RX_DATA,
   output logic RX_VALID,
   output logic RX_FRAME_ERR,
   sat_if.far LINK
);
   typedef enum logic {SAT_RX_IDLE, SAT_RX_RUN} sat_rx_state_t;

   sat_rx_state_t state_r;
   logic [DIV_W-1:0] cnt_r;
   logic rt_r;
   logic [3:0] rt_idx_r;
   logic [3:0] bit_idx_r;
   logic [9:0] sh_r;
   logic [3:0] last_idx;

   assign last_idx = NINE_BIT ? SAT_FRAME_LEN_9 - 4'h1 : SAT_FRAME_LEN_8 - 4'h1;

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         cnt_r <= '0;
         rt_r <= 1'b0;
      end else if (DIVISOR == '0) begin
         cnt_r <= '0;
         rt_r <= 1'b0;
      end else if (cnt_r <= DIV_W'(1)) begin
         cnt_r <= DIVISOR;
         rt_r <= 1'b1;
      end else begin
         cnt_r <= cnt_r - DIV_W'(1);
         rt_r <= 1'b0;
      end
   end

   // Single mid-bit sample; no noise voting at this end
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         state_r <= SAT_RX_IDLE;
         rt_idx_r <= 4'h0;
         bit_idx_r <= 4'h0;
         sh_r <= '0;
         RX_DATA <= 9'h000;
         RX_VALID <= 1'b0;
         RX_FRAME_ERR <= 1'b0;
      end else begin
         RX_VALID <= 1'b0;
         if (rt_r) begin
            case (state_r)
               SAT_RX_IDLE: begin
                  if (!LINK.line) begin
                     state_r <= SAT_RX_RUN;
                     rt_idx_r <= 4'h1;
                     bit_idx_r <= 4'h0;
                  end
               end
               SAT_RX_RUN: begin
                  rt_idx_r <= rt_idx_r + 4'h1;
                  if (rt_idx_r == SAT_RT_MID) begin
                     if (bit_idx_r == 4'h0 && LINK.line) begin
                        state_r <= SAT_RX_IDLE;
                     end else if (bit_idx_r == last_idx) begin
                        state_r <= SAT_RX_IDLE;
                        RX_VALID <= 1'b1;
                        RX_FRAME_ERR <= !LINK.line;
                        RX_DATA <= NINE_BIT ? sh_r[9:1] : {1'b0, sh_r[9:2]};
                     end else begin
                        sh_r <= {LINK.line, sh_r[9:1]};
                     end
                     bit_idx_r <= bit_idx_r + 4'h1;
                  end
               end
               default: state_r <= SAT_RX_IDLE;
            endcase
         end
      end
   end
endmodule // sat_rx_far
`default_nettype wire

// [sat_monitor.sv]
// Checker for the serial line, the register port and the far-end receiver
`timescale 1ns/1ns
`default_nettype none
module sat_monitor (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic txd_o,
   input wire logic txd_oe,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic [31:0] PRDATA,
   input wire logic RX_VALID,
   input wire logic [8:0] RX_DATA
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   logic [7:0] hold_r;
   logic txd_q;
   // Saturating count of cycles since the line level last moved
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         hold_r <= 8'hFF;
         txd_q <= 1'b1;
      end else begin
         txd_q <= txd_o;
         if (txd_o != txd_q) hold_r <= 8'h00;
         else if (hold_r != 8'hFF) hold_r <= hold_r + 8'h01;
      end
   end
   property p_ready_wait;
      $rose(PENABLE) && PSEL |-> !PREADY ##1 PREADY;
   endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("late ready");
   property p_ready_pulse;
      PREADY |=> !PREADY;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("long ready");
   property p_err_ready;
      PSLVERR |-> PREADY && PSEL && PENABLE;
   endproperty
   a_err_ready: assert property (p_err_ready) else $error("stray error");
   property p_err_data;
      PSLVERR |-> PRDATA == 32'h0;
   endproperty
   a_err_data: assert property (p_err_data) else $error("error data");
   property p_idle_ones;
      $rose(txd_oe) |-> txd_o;
   endproperty
   a_idle_ones: assert property (p_idle_ones) else $error("drive not high");
   property p_bit_hold;
      txd_oe && $past(txd_oe) && txd_o != txd_q |-> hold_r >= 8'h0F;
   endproperty
   a_bit_hold: assert property (p_bit_hold) else $error("short bit");
   property p_rx_pulse;
      RX_VALID |=> !RX_VALID;
   endproperty
   a_rx_pulse: assert property (p_rx_pulse) else $error("long valid");
   property p_rx_data;
      !$stable(RX_DATA) |-> RX_VALID;
   endproperty
   a_rx_data: assert property (p_rx_data) else $error("data moved");
   c_err: cover property (PSLVERR);
   c_rx: cover property (RX_VALID);
   c_drive: cover property ($rose(txd_oe));
endmodule // sat_monitor
`default_nettype wire

// [async_serial_transmitter_baudgen_tb.sv]
// Bench: transmitter end against the far-end receiver over one line
`timescale 1ns/1ns
`default_nettype none
module async_serial_transmitter_baudgen_tb;
   import sat_pkg::*;
   logic CLOCK, RST_N, psel, penable, pwrite, pready, pslverr, irq, tick, nine_r, rx_valid;
   logic rx_err, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [12:0] div_r;
   logic [8:0] rx_data;
   logic [10:0] fr;
   int error_cnt = 0;
   int comparisons = 0;
   int wc;
   sat_if sat_if_i ();
   sat_tx_dev sat_tx_dev_i (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .IRQ(irq), .BAUD_RT_TICK(tick), .LINK(sat_if_i.dev));
   sat_rx_far sat_rx_far_i (.CLOCK(CLOCK), .RST_N(RST_N), .DIVISOR(div_r), .NINE_BIT(nine_r),
      .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_FRAME_ERR(rx_err), .LINK(sat_if_i.far));
   sat_monitor sat_monitor_i (.CLOCK(CLOCK), .RST_N(RST_N), .txd_o(sat_if_i.txd_o),
      .txd_oe(sat_if_i.txd_oe), .PSEL(psel), .PENABLE(penable), .PREADY(pready),
      .PSLVERR(pslverr), .PRDATA(prdata), .RX_VALID(rx_valid), .RX_DATA(rx_data));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", n, e, g);
         error_cnt++;
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLOCK);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge CLOCK);
      penable <= 1'b1;
      // Only the watchdog ends a wait for ready
      do begin
         @(posedge CLOCK);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
      apb(1'b0, a, 32'h0);
      chk(n, e, rd);
   endtask
   // Samples the line mid-bit from the falling edge of the start bit
   task automatic frame(input int nb);
      fr = '0;
      wc = 0;
      while (sat_if_i.line !== 1'b0 && wc < 3000) begin
         @(posedge CLOCK);
         wc++;
      end
      repeat (8 * div_r) @(posedge CLOCK);
      for (int i = 0; i < nb; i++) begin
         fr[i] = sat_if_i.line;
         if (i < nb - 1) repeat (16 * div_r) @(posedge CLOCK);
      end
   endtask
   task automatic t_regs;
      chk("idle", 32'h1, sat_if_i.line);
      rdchk(SAT_OFS_BAUD, 32'h4, "baud");
      rdchk(SAT_OFS_STATUS1, 32'h3, "status");
      rdchk(SAT_OFS_DATA_LO, 32'h0, "data_lo");
      rdchk(8'h20, 32'h0, "unmapped");
      chk("slverr", 32'h1, err);
   endtask
   task automatic t_modes;
      logic [2:0] c1 [6] = '{3'h0, 3'h1, 3'h3, 3'h6, 3'h2, 3'h7};
      logic dh [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
      logic [7:0] dl [6] = '{8'hA5, 8'h5A, 8'h07, 8'h03, 8'h80, 8'h07};
      logic [8:0] ex [6] = '{9'h0A5, 9'h15A, 9'h107, 9'h083, 9'h000, 9'h007};
      logic [31:0] e;
      int nb;
      apb(1'b1, SAT_OFS_BAUD, 32'h2);
      div_r <= 13'h0002;
      for (int m = 0; m < 6; m++) begin
         nb = c1[m][0] ? 11 : 10;
         e = (nb == 11) ? {21'h0, 1'b1, ex[m], 1'b0} : {22'h0, 1'b1, ex[m][7:0], 1'b0};
         repeat (40) @(posedge CLOCK);
         nine_r <= c1[m][0];
         apb(1'b1, SAT_OFS_CTRL2, 32'h0);
         apb(1'b1, SAT_OFS_CTRL1, {29'h0, c1[m]});
         apb(1'b1, SAT_OFS_CTRL2, 32'h1);
         apb(1'b0, SAT_OFS_STATUS1, 32'h0);
         apb(1'b1, SAT_OFS_DATA_HI, {31'h0, dh[m]});
         apb(1'b1, SAT_OFS_DATA_LO, {24'h0, dl[m]});
         frame(nb);
         chk("frame", e, {21'h0, fr});
         chk("preamble", 32'h1, wc + 12 >= nb * 32 - 8 && wc + 12 <= nb * 32 + 40);
         repeat (40) @(posedge CLOCK);
         chk("rx_data", {23'h0, ex[m]}, rx_data);
         chk("rx_err", 32'h0, rx_err);
         rdchk(SAT_OFS_DATA_HI, {31'h0, dh[m]}, "ninth");
      end
   endtask
   task automatic t_stream;
      apb(1'b1, SAT_OFS_CTRL2, 32'h0);
      apb(1'b1, SAT_OFS_CTRL1, 32'h0);
      nine_r <= 1'b0;
      apb(1'b1, SAT_OFS_CTRL2, 32'h3);
      repeat (2) @(posedge CLOCK);
      chk("irq", 32'h1, irq);
      apb(1'b0, SAT_OFS_STATUS1, 32'h0);
      apb(1'b1, SAT_OFS_DATA_LO, 32'h3C);
      repeat (2) @(posedge CLOCK);
      chk("irq_clr", 32'h0, irq);
      wc = 0;
      while (irq !== 1'b1 && wc < 2000) begin
         @(posedge CLOCK);
         wc++;
      end
      rdchk(SAT_OFS_STATUS1, 32'h1, "empty");
      apb(1'b1, SAT_OFS_DATA_LO, 32'hC3);
      frame(10);
      chk("frame1", 32'h278, {21'h0, fr});
      frame(10);
      chk("frame2", 32'h386, {21'h0, fr});
      chk("gap", 32'h1, wc <= 20);
      // Message gap: last frame loaded, so toggle enable, then the next first byte
      apb(1'b1, SAT_OFS_CTRL2, 32'h2);
      apb(1'b1, SAT_OFS_CTRL2, 32'h3);
      apb(1'b0, SAT_OFS_STATUS1, 32'h0);
      apb(1'b1, SAT_OFS_DATA_LO, 32'h5A);
      frame(10);
      chk("msg_gap", 32'h1, wc >= 300 && wc <= 360);
      chk("frame3", 32'h2B4, {21'h0, fr});
   endtask
   task automatic t_disable;
      fork
         frame(10);
         begin
            apb(1'b0, SAT_OFS_STATUS1, 32'h0);
            apb(1'b1, SAT_OFS_DATA_LO, 32'h55);
            @(negedge sat_if_i.line);
            apb(1'b0, SAT_OFS_STATUS1, 32'h0);
            apb(1'b1, SAT_OFS_DATA_LO, 32'h11);
            apb(1'b1, SAT_OFS_CTRL2, 32'h0);
         end
      join
      chk("cut", 32'h2AA, {21'h0, fr});
      wc = 0;
      repeat (700) begin
         @(posedge CLOCK);
         if (sat_if_i.line !== 1'b1) wc++;
      end
      chk("released", 32'h0, wc);
      chk("oe_off", 32'h0, sat_if_i.txd_oe);
      rdchk(SAT_OFS_STATUS1, 32'h3, "dropped");
   endtask
   task automatic t_port;
      apb(1'b1, SAT_OFS_PORT_OUT, 32'h2);
      apb(1'b1, SAT_OFS_PORT_DIR, 32'h2);
      // Driven level stands over 20 cycles, past the 15 that the line monitor expects
      repeat (20) @(posedge CLOCK);
      chk("port_oe", 32'h1, sat_if_i.txd_oe);
      apb(1'b1, SAT_OFS_PORT_OUT, 32'h0);
      repeat (2) @(posedge CLOCK);
      chk("port_low", 32'h0, sat_if_i.line);
      apb(1'b1, SAT_OFS_PORT_DIR, 32'h0);
      repeat (2) @(posedge CLOCK);
      chk("port_rel", 32'h1, sat_if_i.line);
   endtask
   task automatic t_baud;
      apb(1'b1, SAT_OFS_BAUD, 32'h4);
      wc = 0;
      repeat (160) begin
         @(posedge CLOCK);
         wc += tick;
      end
      chk("ticks", 32'h1, wc >= 39 && wc <= 41);
      apb(1'b1, SAT_OFS_BAUD, 32'h0);
      repeat (20) @(posedge CLOCK);
      wc = 0;
      repeat (160) begin
         @(posedge CLOCK);
         wc += tick;
      end
      chk("ticks0", 32'h0, wc);
   endtask
   task automatic stop_test;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      CLOCK = 1'b0;
      forever #2 CLOCK = ~CLOCK;
   end
   // Whole run is near 8k cycles; the limit leaves ample slack
   initial begin
      #100000;
      error_cnt++;
      stop_test();
   end
   initial begin
      RST_N = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      div_r = 13'h0004;
      nine_r = 1'b0;
      repeat (4) @(posedge CLOCK);
      RST_N <= 1'b1;
      t_regs();
      t_modes();
      t_stream();
      t_disable();
      t_port();
      t_baud();
      stop_test();
   end
endmodule // async_serial_transmitter_baudgen_tb
`default_nettype wire
